// ==== pmux_defs.svh ====
// Overview of operation
// - One direction bit per pin; 0 is push-pull output, 1 input; resets to 1.
// - Reading port data of an input pin returns the live pin level.
// - Reading port data of an output pin returns the output latch.
// - Each pin owns one direction bit, changeable alone at any time.
// - Input select bits 7..6 route periodic-timer clock: 01 A6, 10 A7, 11 B1.
// - Input select bit 5 set routes standard-timer clock from A2.
// - Input select bit 4 picks standard-timer capture: 0 A6, 1 A0.
// - Input select bit 3 picks periodic-timer capture: 0 A5, 1 B0.
// - Input select bits 1..0 route interrupt: 01 A2, 11 A5, others reserved.
// - Unimplemented select bits ignore writes and read zero.
// - Port A select bit 7 set drives inverted standard-timer output on A7.
// - Port A select bit 7 acts only while reset pin control holds 55h.
// - Port A select bit 6 set drives standard-timer output on A6.
// - Output latch keeps its value until its data register is written.
// - Port data registers reset to all ones.
`ifndef PMUX_DEFS_SVH
`define PMUX_DEFS_SVH

`define PMUX_OFF_PA_DATA  8'h00
`define PMUX_OFF_PA_DIR   8'h04
`define PMUX_OFF_PB_DATA  8'h08
`define PMUX_OFF_PB_DIR   8'h0C
`define PMUX_OFF_PA_SEL   8'h10
`define PMUX_OFF_PB_SEL   8'h14
`define PMUX_OFF_IN_SEL   8'h18

`define PMUX_RST_PA       8'hFF
`define PMUX_RST_PB       6'h3F
`define PMUX_RST_SEL      8'h00
`define PMUX_MASK_PA_SEL  8'hE0
`define PMUX_MASK_PB_SEL  8'h3E
`define PMUX_MASK_IN_SEL  8'hFB
`define PMUX_RESET_PIN_CONTROL_KEY     8'h55

`define PMUX_PA7_SEL      7
`define PMUX_PA6_SEL      6
`define PMUX_PB5_SEL      5
`define PMUX_PB1_SEL      1
`define PMUX_IS_STCLK     5
`define PMUX_IS_STCAP     4
`define PMUX_IS_PTCAP     3

`endif

// ==== pmux_pkg.sv ====
package pmux_pkg;

    typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_READ} pmux_phase_t;

    typedef struct packed {
        logic ptimer_clock_in;
        logic stimer_clock_in;
        logic stimer_capture_in;
        logic ptimer_capture_in;
        logic ext_irq_in;
    } pmux_route_t;

endpackage : pmux_pkg

// ==== pmux_top.sv ====
`timescale 1ns/1ps
`include "pmux_defs.svh"

module pmux_top #(
    parameter int PB_W = 6
) (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire logic [7:0]           reset_pin_control,
    input  wire logic [7:0]           pa_in,
    output logic      [7:0]           pa_out,
    output logic      [7:0]           pa_oe,
    input  wire logic [PB_W-1:0]      pb_in,
    output logic      [PB_W-1:0]      pb_out,
    output logic      [PB_W-1:0]      pb_oe,
    input  wire logic                 stimer_out,
    input  wire logic                 stimer_out_inverted,
    input  wire logic                 ptimer_out,
    output pmux_pkg::pmux_route_t     route
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    pmux_pkg::pmux_phase_t  phase_q;
    logic [7:0]             addr_q;
    logic [31:0]            hrdata_q;
    logic                   hreadyout_q;
    logic [7:0]             pa_data_q;
    logic [7:0]             pa_dir_q;
    logic [PB_W-1:0]        pb_data_q;
    logic [PB_W-1:0]        pb_dir_q;
    logic [7:0]             pa_sel_q;
    logic [7:0]             pb_sel_q;
    logic [7:0]             in_sel_q;
    logic [7:0]             pa_out_q;
    logic [7:0]             pa_oe_q;
    logic [PB_W-1:0]        pb_out_q;
    logic [PB_W-1:0]        pb_oe_q;
    pmux_pkg::pmux_route_t  route_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire        take     = hsel && htrans[1] && hready;
    wire        wr_en    = (phase_q == pmux_pkg::PH_WRITE);
    wire        hit_pa_d = (addr_q == `PMUX_OFF_PA_DATA);
    wire        hit_pa_c = (addr_q == `PMUX_OFF_PA_DIR);
    wire        hit_pb_d = (addr_q == `PMUX_OFF_PB_DATA);
    wire        hit_pb_c = (addr_q == `PMUX_OFF_PB_DIR);
    wire        hit_pa_s = (addr_q == `PMUX_OFF_PA_SEL);
    wire        hit_pb_s = (addr_q == `PMUX_OFF_PB_SEL);
    wire        hit_in_s = (addr_q == `PMUX_OFF_IN_SEL);
    wire [7:0]  wbyte    = hwdata[7:0];

    // Input pins show the pad, output pins show the latch
    wire [7:0]      pa_read = (pa_dir_q & pa_in) | (~pa_dir_q & pa_data_q);
    wire [PB_W-1:0] pb_read = (pb_dir_q & pb_in) | (~pb_dir_q & pb_data_q);

    wire [7:0] rd_byte =
          ({8{hit_pa_d}} & pa_read)
        | ({8{hit_pa_c}} & pa_dir_q)
        | ({8{hit_pb_d}} & {{(8-PB_W){1'b0}}, pb_read})
        | ({8{hit_pb_c}} & {{(8-PB_W){1'b0}}, pb_dir_q})
        | ({8{hit_pa_s}} & pa_sel_q)
        | ({8{hit_pb_s}} & pb_sel_q)
        | ({8{hit_in_s}} & in_sel_q);

    // Reads take one wait state so a write just before is always seen
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase_q     <= pmux_pkg::PH_IDLE;
            addr_q      <= 8'h00;
            hreadyout_q <= 1'b1;
            hrdata_q    <= 32'h0000_0000;
        end
        else if (phase_q == pmux_pkg::PH_READ)
        begin
            phase_q     <= pmux_pkg::PH_IDLE;
            hreadyout_q <= 1'b1;
            hrdata_q    <= {24'h00_0000, rd_byte};
        end
        else if (take)
        begin
            phase_q     <= hwrite ? pmux_pkg::PH_WRITE : pmux_pkg::PH_READ;
            addr_q      <= haddr[7:0];
            hreadyout_q <= hwrite;
        end
        else
        begin
            phase_q <= pmux_pkg::PH_IDLE;
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pa_data_q <= `PMUX_RST_PA;
            pb_data_q <= `PMUX_RST_PB;
            pa_dir_q  <= `PMUX_RST_PA;
            pb_dir_q  <= `PMUX_RST_PB;
            pa_sel_q  <= `PMUX_RST_SEL;
            pb_sel_q  <= `PMUX_RST_SEL;
            in_sel_q  <= `PMUX_RST_SEL;
        end
        else if (wr_en)
        begin
            // Latches change only on their own write
            if (hit_pa_d)
                pa_data_q <= wbyte;
            if (hit_pb_d)
                pb_data_q <= wbyte[PB_W-1:0];
            // Whole-byte write, each bit steers only its own pin
            if (hit_pa_c)
                pa_dir_q <= wbyte;
            if (hit_pb_c)
                pb_dir_q <= wbyte[PB_W-1:0];
            if (hit_pa_s)
                pa_sel_q <= wbyte & `PMUX_MASK_PA_SEL;
            // Bits 4..2 are stored but steer nothing
            if (hit_pb_s)
                pb_sel_q <= wbyte & `PMUX_MASK_PB_SEL;
            if (hit_in_s)
                in_sel_q <= wbyte & `PMUX_MASK_IN_SEL;
        end
    end

    // ------------------------------------------------------------
    // Output function selection
    // ------------------------------------------------------------
    wire reset_pin_control_ok = (reset_pin_control == `PMUX_RESET_PIN_CONTROL_KEY);
    wire pa7_fn  = pa_sel_q[`PMUX_PA7_SEL] && reset_pin_control_ok;
    wire pa6_fn  = pa_sel_q[`PMUX_PA6_SEL];
    wire pb5_fn  = pb_sel_q[`PMUX_PB5_SEL];
    wire pb1_fn  = pb_sel_q[`PMUX_PB1_SEL];

    wire [7:0]      pa_fsel = {pa7_fn, pa6_fn, 6'b00_0000};
    wire [7:0]      pa_fval = {stimer_out_inverted, stimer_out, 6'b00_0000};
    wire [PB_W-1:0] pb_fsel = PB_W'({pb5_fn, 3'b000, pb1_fn, 1'b0});
    wire [PB_W-1:0] pb_fval = PB_W'({ptimer_out, 3'b000, stimer_out_inverted, 1'b0});

    // A selected timer output owns the driver and forces it on
    wire [7:0]      pa_out_d = (pa_fsel & pa_fval) | (~pa_fsel & pa_data_q);
    wire [PB_W-1:0] pb_out_d = (pb_fsel & pb_fval) | (~pb_fsel & pb_data_q);
    wire [7:0]      pa_oe_d  = ~pa_dir_q | pa_fsel;
    wire [PB_W-1:0] pb_oe_d  = ~pb_dir_q | pb_fsel;

    // ------------------------------------------------------------
    // Input source routing
    // ------------------------------------------------------------
    // Four-way pick, reserved code reads as low
    function automatic logic pick4(input logic [1:0] s, input logic a, input logic b, input logic c);
        pick4 = (s == 2'b01) ? a : (s == 2'b10) ? b : (s == 2'b11) ? c : 1'b0;
    endfunction : pick4

    pmux_pkg::pmux_route_t route_d;
    assign route_d.ptimer_clock_in   = pick4(in_sel_q[7:6], pa_in[6], pa_in[7], pb_in[1]);
    assign route_d.stimer_clock_in   = in_sel_q[`PMUX_IS_STCLK] & pa_in[2];
    assign route_d.stimer_capture_in = in_sel_q[`PMUX_IS_STCAP] ? pa_in[0] : pa_in[6];
    assign route_d.ptimer_capture_in = in_sel_q[`PMUX_IS_PTCAP] ? pb_in[0] : pa_in[5];
    assign route_d.ext_irq_in        = pick4(in_sel_q[1:0], pa_in[2], 1'b0, pa_in[5]);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pa_out_q <= `PMUX_RST_PA;
            pb_out_q <= `PMUX_RST_PB;
            pa_oe_q  <= 8'h00;
            pb_oe_q  <= '0;
            route_q  <= '0;
        end
        else
        begin
            pa_out_q <= pa_out_d;
            pb_out_q <= pb_out_d;
            pa_oe_q  <= pa_oe_d;
            pb_oe_q  <= pb_oe_d;
            route_q  <= route_d;
        end
    end

    assign hrdata    = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp     = 1'b0;
    assign pa_out    = pa_out_q;
    assign pa_oe     = pa_oe_q;
    assign pb_out    = pb_out_q;
    assign pb_oe     = pb_oe_q;
    assign route     = route_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_RD_WAIT: assert property (take && !hwrite && phase_q != pmux_pkg::PH_READ
        |=> !hreadyout_q ##1 hreadyout_q)
        else $error("read wait state wrong");

    AST_RD_INPUT: assert property ((phase_q == pmux_pkg::PH_READ) && hit_pa_d && (pa_dir_q == 8'hFF)
        |=> hrdata_q[7:0] == $past(pa_in))
        else $error("input pin read not live level");

    AST_RD_LATCH: assert property ((phase_q == pmux_pkg::PH_READ) && hit_pb_d
        |=> ((hrdata_q[PB_W-1:0] ^ $past(pb_data_q)) & ~$past(pb_dir_q)) == '0)
        else $error("output pin read not latch");

    AST_LATCH_HOLD: assert property (!(wr_en && hit_pa_d) |=> $stable(pa_data_q))
        else $error("latch changed without write");

    AST_PA7_KEY: assert property (!reset_pin_control_ok && !pa_dir_q[7] |=> pa_out_q[7] == $past(pa_data_q[7]))
        else $error("port A bit 7 select acted without key");

    AST_PA6_FN: assert property (pa_sel_q[`PMUX_PA6_SEL] |=> pa_oe_q[6] && pa_out_q[6] == $past(stimer_out))
        else $error("port A bit 6 not timer driven");

    AST_PB5_FN: assert property (pb5_fn |=> pb_oe_q[5] && pb_out_q[5] == $past(ptimer_out))
        else $error("port B bit 5 not timer driven");

    AST_PB1_FN: assert property (pb1_fn |=> pb_out_q[1] == $past(stimer_out_inverted))
        else $error("port B bit 1 not inverted timer");

    AST_PT_CLK: assert property (in_sel_q[7:6] == 2'b11 |=> route_q.ptimer_clock_in == $past(pb_in[1]))
        else $error("periodic clock route wrong");

    AST_IRQ_RSV: assert property (in_sel_q[1:0] == 2'b10 |=> !route_q.ext_irq_in)
        else $error("reserved interrupt code routed");

    AST_SEL_ZERO: assert property (wr_en && hit_in_s |=> in_sel_q[2] == 1'b0 && pa_sel_q[4:0] == 5'h00)
        else $error("unimplemented select bit set");

    AST_DIR_OE: assert property (wr_en && hit_pa_c && !pa_fsel[0] |=> ##1 pa_oe_q[0] == !$past(wbyte[0], 2))
        else $error("direction write not on pin");

    // ------------------------------------------------------------
    // Reset state and per-pin ownership
    // ------------------------------------------------------------
    // Nothing drives a pad until software asks, and latches wait high
    AST_RST_STATE: assert property ($rose(hresetn) |-> pa_dir_q == `PMUX_RST_PA && pb_dir_q == `PMUX_RST_PB
        && pa_data_q == `PMUX_RST_PA && pb_data_q == `PMUX_RST_PB && !(|pa_oe_q) && !(|pb_oe_q))
        else $error("port state wrong after reset");

    // Each direction bit and latch bit steers its own pad alone
    for (genvar i = 0; i < 8; i++)
    begin : g_pa_pin
        AST_PA_PIN_OE: assert property (!pa_fsel[i] |=> pa_oe_q[i] == !$past(pa_dir_q[i]))
            else $error("port A pad enable not from its direction bit");
        AST_PA_PIN_OUT: assert property (!pa_fsel[i] |=> pa_out_q[i] == $past(pa_data_q[i]))
            else $error("port A pad not from its latch");
    end

    for (genvar i = 0; i < PB_W; i++)
    begin : g_pb_pin
        AST_PB_PIN_OE: assert property (!pb_fsel[i] |=> pb_oe_q[i] == !$past(pb_dir_q[i]))
            else $error("port B pad enable not from its direction bit");
        AST_PB_PIN_OUT: assert property (!pb_fsel[i] |=> pb_out_q[i] == $past(pb_data_q[i]))
            else $error("port B pad not from its latch");
    end

    // ------------------------------------------------------------
    // Shared output functions
    // ------------------------------------------------------------
    AST_PA7_FN: assert property (pa7_fn |=> pa_oe_q[7] && pa_out_q[7] == $past(stimer_out_inverted))
        else $error("port A bit 7 not inverted timer");

    AST_PA7_IDLE: assert property (!reset_pin_control_ok && pa_dir_q[7] |=> !pa_oe_q[7])
        else $error("port A bit 7 driven without key");

    AST_PB1_OE: assert property (pb1_fn |=> pb_oe_q[1])
        else $error("port B bit 1 driver not forced on");

    // ------------------------------------------------------------
    // Input routes
    // ------------------------------------------------------------
    AST_PT_CLK_LO: assert property (in_sel_q[7:6] == 2'b01 |=> route_q.ptimer_clock_in == $past(pa_in[6]))
        else $error("periodic clock not from port A bit 6");

    AST_PT_CLK_HI: assert property (in_sel_q[7:6] == 2'b10 |=> route_q.ptimer_clock_in == $past(pa_in[7]))
        else $error("periodic clock not from port A bit 7");

    AST_PT_CLK_RSV: assert property (in_sel_q[7:6] == 2'b00 |=> !route_q.ptimer_clock_in)
        else $error("reserved periodic clock code routed");

    AST_ST_CLK_ON: assert property (in_sel_q[`PMUX_IS_STCLK]
        |=> route_q.stimer_clock_in == $past(pa_in[2]))
        else $error("standard clock not from port A bit 2");

    AST_ST_CLK_OFF: assert property (!in_sel_q[`PMUX_IS_STCLK] |=> !route_q.stimer_clock_in)
        else $error("reserved standard clock code routed");

    AST_ST_CAP_A0: assert property (in_sel_q[`PMUX_IS_STCAP]
        |=> route_q.stimer_capture_in == $past(pa_in[0]))
        else $error("standard capture not from port A bit 0");

    AST_ST_CAP_A6: assert property (!in_sel_q[`PMUX_IS_STCAP]
        |=> route_q.stimer_capture_in == $past(pa_in[6]))
        else $error("standard capture not from port A bit 6");

    AST_PT_CAP_B0: assert property (in_sel_q[`PMUX_IS_PTCAP]
        |=> route_q.ptimer_capture_in == $past(pb_in[0]))
        else $error("periodic capture not from port B bit 0");

    AST_PT_CAP_A5: assert property (!in_sel_q[`PMUX_IS_PTCAP]
        |=> route_q.ptimer_capture_in == $past(pa_in[5]))
        else $error("periodic capture not from port A bit 5");

    AST_IRQ_A2: assert property (in_sel_q[1:0] == 2'b01 |=> route_q.ext_irq_in == $past(pa_in[2]))
        else $error("interrupt not from port A bit 2");

    AST_IRQ_A5: assert property (in_sel_q[1:0] == 2'b11 |=> route_q.ext_irq_in == $past(pa_in[5]))
        else $error("interrupt not from port A bit 5");

    // ------------------------------------------------------------
    // Register contents
    // ------------------------------------------------------------
    AST_SEL_MASK: assert property (!(|(pa_sel_q & ~`PMUX_MASK_PA_SEL))
        && !(|(pb_sel_q & ~`PMUX_MASK_PB_SEL))
        && !(|(in_sel_q & ~`PMUX_MASK_IN_SEL)))
        else $error("unimplemented select bit holds a one");

    AST_WR_LAND: assert property (wr_en && hit_pa_d |=> pa_data_q == $past(wbyte))
        else $error("port A latch write lost");

    AST_LATCH_HOLD_B: assert property (!(wr_en && hit_pb_d) |=> $stable(pb_data_q))
        else $error("port B latch changed without write");

    AST_RD_PA_INPUT: assert property ((phase_q == pmux_pkg::PH_READ) && hit_pa_d
        |=> ((hrdata_q[7:0] ^ $past(pa_in)) & $past(pa_dir_q)) == 8'h00)
        else $error("input bits of port A read wrong");

    AST_RD_PA_LATCH: assert property ((phase_q == pmux_pkg::PH_READ) && hit_pa_d
        |=> ((hrdata_q[7:0] ^ $past(pa_data_q)) & ~$past(pa_dir_q)) == 8'h00)
        else $error("output bits of port A read wrong");

endmodule : pmux_top

// ==== pmux_pins.sv ====
`timescale 1ns/1ps

module pmux_pins (
    input  wire logic [7:0] pa_out,
    input  wire logic [7:0] pa_oe,
    input  wire logic [5:0] pb_out,
    input  wire logic [5:0] pb_oe,
    input  wire logic [7:0] pa_ext,
    input  wire logic [5:0] pb_ext,
    input  wire logic [7:0] pa_short,
    input  wire logic       stm,
    input  wire logic       ptm,
    output logic      [7:0] pa_in,
    output logic      [5:0] pb_in,
    output logic            stimer_out,
    output logic            stimer_out_inverted,
    output logic            ptimer_out
);
    // ----------------------------------------
    // Pads
    // ----------------------------------------
    // A shorted output pad reads back the opposite level, so latch and pin can differ
    assign pa_in = (pa_oe & (pa_out ^ pa_short)) | (~pa_oe & pa_ext);
    assign pb_in = (pb_oe & pb_out) | (~pb_oe & pb_ext);
    // ----------------------------------------
    // Timers
    // ----------------------------------------
    assign stimer_out          = stm;
    assign stimer_out_inverted = ~stm;
    assign ptimer_out          = ptm;
endmodule : pmux_pins

// ==== port_direction_and_pin_mux_tb_top.sv ====
`timescale 1ns/1ps

module port_direction_and_pin_mux_tb_top;
    typedef struct packed {logic [7:0] addr; logic [7:0] wd; logic [7:0] rd;} pmux_row_t;
    logic                  hclk, hresetn, hsel, hwrite, hreadyout, hresp, stm, ptm, st, stb, pt;
    logic [31:0]           haddr, hwdata, hrdata, rdv;
    logic [1:0]            htrans;
    logic [2:0]            hsize;
    logic [7:0]            rpc, pa_in, pa_out, pa_oe, pa_ext, pa_short;
    logic [5:0]            pb_in, pb_out, pb_oe, pb_ext;
    pmux_pkg::pmux_route_t route;
    int                    errors, checks_done, cycles;
    pmux_row_t rows [11] = '{'{8'h10, 8'hDF, 8'hC0}, '{8'h10, 8'h00, 8'h00}, '{8'h14, 8'hE3, 8'h22},
        '{8'h14, 8'h00, 8'h00}, '{8'h18, 8'hFF, 8'hFB}, '{8'h18, 8'h04, 8'h00}, '{8'h0C, 8'h2A, 8'h2A},
        '{8'h0C, 8'hFF, 8'h3F}, '{8'h04, 8'h5A, 8'h5A}, '{8'h04, 8'hFF, 8'hFF}, '{8'h40, 8'h77, 8'h00}};

    pmux_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .reset_pin_control(rpc), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
        .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .stimer_out(st), .stimer_out_inverted(stb),
        .ptimer_out(pt), .route(route));
    pmux_pins pins (.pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe), .pa_ext(pa_ext),
        .pb_ext(pb_ext), .pa_short(pa_short), .stm(stm), .ptm(ptm), .pa_in(pa_in), .pb_in(pb_in),
        .stimer_out(st), .stimer_out_inverted(stb), .ptimer_out(pt));

    // ----------------------------------------
    // Clock and watchdog
    // ----------------------------------------
    initial
    begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors++;
            test_done();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic test_done();
        $display("Checks %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask : chk

    // Waits on hready with no cycle count assumed; only the watchdog ends a hang
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0000_00, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0000_00, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask : bus

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk("read data", {24'h0000_00, exp}, rdv);
        chk("response", 32'h0000_0000, {31'h0000_0000, hresp});
    endtask : rd_chk

    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
    endtask : do_reset

    // Pin and route outputs trail their cause by one edge; settle waits three edges
    task automatic settle();
        repeat (3) @(posedge hclk);
        #1;
    endtask : settle

    function automatic pmux_pkg::pmux_route_t route_exp(input logic [1:0] k, input logic [7:0] a,
                                                          input logic [5:0] b);
        pmux_pkg::pmux_route_t r;
        r.ptimer_clock_in   = (k == 2'd1) ? a[6] : (k == 2'd2) ? a[7] : (k == 2'd3) ? b[1] : 1'b0;
        r.stimer_clock_in   = a[2];
        r.stimer_capture_in = k[0] ? a[0] : a[6];
        r.ptimer_capture_in = k[1] ? b[0] : a[5];
        r.ext_irq_in        = (k == 2'd1) ? a[2] : (k == 2'd3) ? a[5] : 1'b0;
        return r;
    endfunction : route_exp

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial
    begin
        {hresetn, hsel, hwrite, stm, ptm} = 5'b0;
        {haddr, hwdata} = 64'h0000_0000_0000_0000;
        errors = 0;
        checks_done = 0;
        cycles = 0;
        htrans = 2'b00;
        hsize = 3'b010;
        rpc = 8'h00;
        {pa_ext, pa_short, pb_ext} = 22'h00_0000;
        do_reset();
        foreach (rows[i])
        begin
            bus(1'b1, rows[i].addr, rows[i].wd);
            rd_chk(rows[i].addr, rows[i].rd);
        end
        pa_ext <= 8'hA5;
        pb_ext <= 6'h15;
        do_reset();
        settle();
        chk("oe after reset", 32'h0000_0000, {18'h0_0000, pa_oe, pb_oe});
        rd_chk(8'h04, 8'hFF);
        rd_chk(8'h0C, 8'h3F);
        rd_chk(8'h00, 8'hA5);
        rd_chk(8'h08, 8'h15);
        rd_chk(8'h18, 8'h00);
        pa_short <= 8'hFF;
        bus(1'b1, 8'h04, 8'h00);
        settle();
        chk("pa drive", 32'h0000_FFFF, {16'h0000, pa_oe, pa_out});
        rd_chk(8'h00, 8'hFF);
        bus(1'b1, 8'h00, 8'h3C);
        bus(1'b1, 8'h04, 8'h0F);
        settle();
        chk("pa driven bits", 32'h0000_F030, {16'h0000, pa_oe, pa_out & pa_oe});
        rd_chk(8'h00, 8'h35);
        pa_short <= 8'h00;
        // Unbonded A3/A4 and transmitter lines stay outputs; timer inputs stay inputs
        bus(1'b1, 8'h04, 8'hE7);
        bus(1'b1, 8'h0C, 8'h23);
        rd_chk(8'h08, 8'h1D);
        for (int k = 0; k < 4; k++)
        begin
            bus(1'b1, 8'h18, {k[1:0], 1'b1, k[0], k[1], 1'b0, k[1:0]});
            for (int j = 0; j < 8; j++)
            begin
                @(posedge hclk);
                pa_ext <= 8'h01 << j;
                pb_ext <= 6'h01 << j;
                settle();
                chk("route", {27'h000_0000, route_exp(k[1:0], 8'h01 << j, 6'h01 << j)}, {27'h000_0000, route});
            end
        end
        // Functions are selected before the timers start toggling
        bus(1'b1, 8'h14, 8'h22);
        bus(1'b1, 8'h10, 8'hC0);
        for (int r = 0; r < 2; r++)
        begin
            for (int t = 0; t < 2; t++)
            begin
                @(posedge hclk);
                rpc <= r[0] ? 8'h55 : 8'h54;
                stm <= t[0];
                ptm <= ~t[0];
                settle();
                chk("timer pins", {27'h000_0000, 1'b1, r[0] & ~t[0], t[0], ~t[0], ~t[0]},
                    {27'h000_0000, pa_oe[6], pa_out[7:6], pb_out[5], pb_out[1]});
            end
        end
        test_done();
    end
endmodule : port_direction_and_pin_mux_tb_top
